/* src/pic_ctrl.sv */
`timescale 1ns/1ps
module pic_ctrl (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       csB,
   input  wire logic       wrB,
   input  wire logic       rdB,
   input  wire logic       regSel,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] dataOut,
   output logic            dataOe,
   input  wire logic [7:0] reqIn,
   input  wire logic       ackB,
   input  wire logic       roleBufEnIn,
   output logic            roleBufEnOut,
   output logic            roleBufEnOe,
   output logic            intReq,
   output logic            isMaster,
   output logic      [7:0] slaveMap,
   output logic      [2:0] slaveId,
   output logic            nestSpecial,
   output logic            autoEnd,
   output logic            procMode,
   output logic            initDone
);
   pic_prio_if prio ();

   pic_pkg::pic_init_type initState_ff;
   pic_pkg::pic_cmd_type  cmd;
   logic       wrPrev_ff;
   logic       ackPrev_ff;
   logic [7:0] reqPrev_ff;
   logic       single_ff;
   logic       fourth_ff;
   logic [7:0] cascade_ff;
   logic [7:0] mode_ff;
   logic [7:0] mask_ff;
   logic [7:0] pending_ff;
   logic [7:0] service_ff;
   logic [2:0] lowest_ff;
   logic       rotateAuto_ff;
   logic [1:0] ackCnt_ff;
   logic [2:0] ackLvl_ff;
   logic       ackHit_ff;
   logic       intReq_ff;
   logic       isMaster_ff;
   logic [7:0] slaveMap_ff;
   logic [2:0] slaveId_ff;
   logic [7:0] dataOut_ff;
   logic       dataOe_ff;
   logic       initDone_ff;
   logic       roleBufEnOut_ff;
   logic       roleBufEnOe_ff;
   logic       wrActive;
   logic       wrTake;
   logic       initStart;
   logic       initWord;
   logic       maskWrite;
   logic       cmdWrite;
   logic       ackActive;
   logic       ackFall;
   logic       ackRise;
   logic       ackTake;
   logic       ackFinal;
   logic       autoFinal;
   logic [1:0] ackNeed;
   logic [2:0] cmdLvl;
   logic [7:0] nxt_pending;
   logic [7:0] nxt_service;
   logic [7:0] svcClr;
   // Bus strobes are taken once, on the cycle they first go active
   assign wrActive  = !csB && !wrB;
   assign wrTake    = wrActive && !wrPrev_ff;
   assign initStart = wrTake && !regSel && dataIn[pic_pkg::INIT_BIT];
   assign initWord  = wrTake && regSel && initState_ff != pic_pkg::INIT_READY;
   assign maskWrite = wrTake && regSel && initState_ff == pic_pkg::INIT_READY;
   // Bits 4..3 both zero tell the end/rotate word apart; 0/1 is out of this block
   assign cmdWrite  = wrTake && !regSel && !dataIn[pic_pkg::INIT_BIT] && !dataIn[pic_pkg::SEL3_BIT] &&
                      initState_ff == pic_pkg::INIT_READY;
   assign cmd       = pic_pkg::pic_cmd_type'(dataIn[7:pic_pkg::CMD_LSB]);
   assign cmdLvl    = dataIn[pic_pkg::LVL_MSB:0];
   assign ackActive = !ackB;
   assign ackFall   = ackActive && !ackPrev_ff;
   assign ackRise   = !ackActive && ackPrev_ff;
   assign ackNeed   = mode_ff[pic_pkg::PROC_BIT] ? pic_pkg::ACKS_VECTORED : pic_pkg::ACKS_CALL;
   assign ackTake   = ackFall && ackCnt_ff == 2'h0 && prio.winValid;
   assign ackFinal  = ackRise && 2'(ackCnt_ff + 2'h1) == ackNeed;
   assign autoFinal = ackFinal && ackHit_ff && mode_ff[pic_pkg::AUTO_BIT];

   assign prio.pending     = pending_ff;
   assign prio.mask        = mask_ff;
   assign prio.service     = service_ff;
   assign prio.slaveMap    = cascade_ff;
   assign prio.lowest      = lowest_ff;
   assign prio.nestSpecial = mode_ff[pic_pkg::NEST_BIT];
   assign prio.master      = isMaster_ff;
   pic_prio_resolve u_resolve (
      .prio (prio)
   );

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrPrev_ff  <= 1'b0;
         ackPrev_ff <= 1'b0;
         reqPrev_ff <= 8'h00;
      end
      else
      begin
         wrPrev_ff  <= wrActive;
         ackPrev_ff <= ackActive;
         reqPrev_ff <= reqIn;
      end
   end
   // Initialization sequence
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         initState_ff <= pic_pkg::INIT_READY;
         single_ff    <= 1'b1;
         fourth_ff    <= 1'b0;
      end
      else if (initStart)
      begin
         initState_ff <= pic_pkg::INIT_VEC;
         single_ff    <= dataIn[pic_pkg::SINGLE_BIT];
         fourth_ff    <= dataIn[pic_pkg::FOURTH_BIT];
      end
      else if (initWord)
      begin
         unique case (initState_ff)
            pic_pkg::INIT_VEC:   initState_ff <= !single_ff ? pic_pkg::INIT_CASC :
                                                 fourth_ff ? pic_pkg::INIT_MODE : pic_pkg::INIT_READY;
            pic_pkg::INIT_CASC:  initState_ff <= fourth_ff ? pic_pkg::INIT_MODE : pic_pkg::INIT_READY;
            pic_pkg::INIT_MODE:  initState_ff <= pic_pkg::INIT_READY;
            pic_pkg::INIT_READY: initState_ff <= pic_pkg::INIT_READY;
         endcase
      end
   end
   // Cascade and mode words; mode clears at every restart so a skipped write means 00h
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cascade_ff <= pic_pkg::CASC_RST;
         mode_ff    <= pic_pkg::MODE_RST;
      end
      else if (initStart)
      begin
         mode_ff <= pic_pkg::MODE_RST;
      end
      else if (initWord && initState_ff == pic_pkg::INIT_CASC)
      begin
         cascade_ff <= dataIn;
      end
      else if (initWord && initState_ff == pic_pkg::INIT_MODE)
      begin
         mode_ff <= dataIn;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         mask_ff <= pic_pkg::MASK_RST;
      else if (initStart)
         mask_ff <= pic_pkg::MASK_RST;
      else if (maskWrite)
         mask_ff <= dataIn;
   end
   // Requests latch on rising edges; masking never drops them, new edge beats the clear
   always_comb
   begin
      nxt_pending = pending_ff & ~(ackTake ? 8'h01 << prio.winLvl : 8'h00);
      nxt_pending = nxt_pending | (reqIn & ~reqPrev_ff);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         pending_ff <= 8'h00;
      else
         pending_ff <= nxt_pending;
   end
   // Service bits: set by acknowledge, cleared by commands or automatic end
   always_comb
   begin
      svcClr = 8'h00;
      if (autoFinal)
         svcClr = svcClr | (8'h01 << ackLvl_ff);
      if (cmdWrite && (cmd == pic_pkg::CMD_END_ANY || cmd == pic_pkg::CMD_ROT_END_ANY) && prio.svcValid)
         svcClr = svcClr | (8'h01 << prio.svcLvl);
      if (cmdWrite && (cmd == pic_pkg::CMD_END_LVL || cmd == pic_pkg::CMD_ROT_END_LVL))
         svcClr = svcClr | (8'h01 << cmdLvl);
      nxt_service = (service_ff & ~svcClr) | (ackTake ? 8'h01 << prio.winLvl : 8'h00);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         service_ff <= 8'h00;
      else
         service_ff <= nxt_service;
   end
   // Priority rotation; a command in the same cycle wins over automatic rotation
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lowest_ff     <= pic_pkg::LOWEST_RST;
         rotateAuto_ff <= 1'b0;
      end
      else if (initStart)
      begin
         lowest_ff     <= pic_pkg::LOWEST_RST;
         rotateAuto_ff <= 1'b0;
      end
      else if (cmdWrite)
      begin
         unique case (cmd)
            pic_pkg::CMD_ROT_SET:     rotateAuto_ff <= 1'b1;
            pic_pkg::CMD_ROT_CLR:     rotateAuto_ff <= 1'b0;
            pic_pkg::CMD_ROT_END_ANY: lowest_ff     <= prio.svcValid ? prio.svcLvl : lowest_ff;
            pic_pkg::CMD_ROT_END_LVL: lowest_ff     <= cmdLvl;
            pic_pkg::CMD_SET_LOW:     lowest_ff     <= cmdLvl;
            pic_pkg::CMD_END_ANY,
            pic_pkg::CMD_END_LVL,
            pic_pkg::CMD_NOP:         lowest_ff     <= lowest_ff;
         endcase
      end
      else if (autoFinal && rotateAuto_ff)
      begin
         lowest_ff <= ackLvl_ff;
      end
   end
   // Acknowledge pulse counting; level frozen at the first pulse
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ackCnt_ff <= 2'h0;
         ackLvl_ff <= 3'h0;
         ackHit_ff <= 1'b0;
      end
      else
      begin
         if (ackFall && ackCnt_ff == 2'h0)
         begin
            ackLvl_ff <= prio.winLvl;
            ackHit_ff <= prio.winValid;
         end
         if (ackFinal)
            ackCnt_ff <= 2'h0;
         else if (ackRise)
            ackCnt_ff <= 2'(ackCnt_ff + 2'h1);
      end
   end
   // Role, cascade view and pin control
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         isMaster_ff     <= 1'b1;
         slaveMap_ff     <= 8'h00;
         slaveId_ff      <= 3'h0;
         roleBufEnOe_ff  <= 1'b0;
         roleBufEnOut_ff <= 1'b1;
      end
      else
      begin
         isMaster_ff     <= mode_ff[pic_pkg::BUFFERED_BIT] ? mode_ff[pic_pkg::ROLE_BIT]
                                                           : roleBufEnIn;
         slaveMap_ff     <= isMaster_ff ? cascade_ff : 8'h00;
         slaveId_ff      <= isMaster_ff ? 3'h0 : cascade_ff[2:0];
         roleBufEnOe_ff  <= mode_ff[pic_pkg::BUFFERED_BIT];
         // Enable is low while the data bus is driven by this block
         roleBufEnOut_ff <= !((!csB && !rdB) || ackActive);
      end
   end
   // Reads: select high returns mask, low returns pending requests
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dataOut_ff <= 8'h00;
         dataOe_ff  <= 1'b0;
         intReq_ff  <= 1'b0;
         initDone_ff <= 1'b1;
      end
      else
      begin
         dataOut_ff <= regSel ? mask_ff : pending_ff;
         dataOe_ff  <= !csB && !rdB;
         initDone_ff <= initState_ff == pic_pkg::INIT_READY;
         intReq_ff  <= prio.winValid;
      end
   end

   assign dataOut      = dataOut_ff;
   assign dataOe       = dataOe_ff;
   assign intReq       = intReq_ff;
   assign isMaster     = isMaster_ff;
   assign slaveMap     = slaveMap_ff;
   assign slaveId      = slaveId_ff;
   assign roleBufEnOut = roleBufEnOut_ff;
   assign roleBufEnOe  = roleBufEnOe_ff;
   assign nestSpecial  = mode_ff[pic_pkg::NEST_BIT];
   assign autoEnd      = mode_ff[pic_pkg::AUTO_BIT];
   assign procMode     = mode_ff[pic_pkg::PROC_BIT];
   assign initDone     = initDone_ff;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_init_restart: assert property (initStart |=> initState_ff == pic_pkg::INIT_VEC)
      else $error("Init word did not restart the sequence");
   a_mode_default:
      assert property (initStart |=> mode_ff == pic_pkg::MODE_RST ##1 mode_ff == pic_pkg::MODE_RST)
      else $error("Mode word not cleared on restart");
   a_mask_write: assert property (maskWrite |=> mask_ff == $past(dataIn))
      else $error("Mask write not stored");
   a_role_pin: assert property (!mode_ff[pic_pkg::BUFFERED_BIT] |=> isMaster_ff == $past(roleBufEnIn))
      else $error("Role not taken from pin");
   a_role_bit:
      assert property (mode_ff[pic_pkg::BUFFERED_BIT] && $stable(mode_ff) |=>
                       isMaster_ff == $past(mode_ff[pic_pkg::ROLE_BIT]) && roleBufEnOe_ff)
      else $error("Buffered role wrong");
   a_slave_id:
      assert property (!isMaster_ff |=> slaveId_ff == $past(cascade_ff[2:0]) && slaveMap_ff == 8'h00)
      else $error("Slave identity wrong");
   a_master_map: assert property (isMaster_ff |=> slaveMap_ff == $past(cascade_ff))
      else $error("Master slave map wrong");
   a_masked_quiet: assert property (intReq_ff |-> $past(|(pending_ff & ~mask_ff)))
      else $error("Request raised with nothing unmasked pending");
   a_level_end:
      assert property (cmdWrite && cmd == pic_pkg::CMD_END_LVL && !ackTake |=> !service_ff[$past(cmdLvl)])
      else $error("Specific end left level in service");
   a_auto_end: assert property (autoFinal |=> !service_ff[$past(ackLvl_ff)])
      else $error("Automatic end did not clear level");
   a_set_lowest: assert property (cmdWrite && cmd == pic_pkg::CMD_SET_LOW |=> lowest_ff == $past(cmdLvl))
      else $error("Set lowest priority not applied");
endmodule : pic_ctrl

/* include/pic_pkg.sv */
package pic_pkg;
   localparam logic [7:0] MASK_RST      = 8'h00;
   localparam logic [7:0] MODE_RST      = 8'h00;
   localparam logic [7:0] CASC_RST      = 8'h00;
   localparam logic [2:0] LOWEST_RST    = 3'h7;
   localparam int         INIT_BIT      = 4;
   localparam int         SEL3_BIT      = 3;
   localparam int         SINGLE_BIT    = 1;
   localparam int         FOURTH_BIT    = 0;
   localparam int         NEST_BIT      = 4;
   localparam int         BUFFERED_BIT  = 3;
   localparam int         ROLE_BIT      = 2;
   localparam int         AUTO_BIT      = 1;
   localparam int         PROC_BIT      = 0;
   localparam int         CMD_LSB       = 5;
   localparam int         LVL_MSB       = 2;
   localparam logic [1:0] ACKS_VECTORED = 2'h2;
   localparam logic [1:0] ACKS_CALL     = 2'h3;

   typedef enum logic [1:0] {
      INIT_READY = 2'b00,
      INIT_VEC   = 2'b01,
      INIT_CASC  = 2'b10,
      INIT_MODE  = 2'b11
   } pic_init_type;

   typedef enum logic [2:0] {
      CMD_ROT_CLR     = 3'b000,
      CMD_END_ANY     = 3'b001,
      CMD_NOP         = 3'b010,
      CMD_END_LVL     = 3'b011,
      CMD_ROT_SET     = 3'b100,
      CMD_ROT_END_ANY = 3'b101,
      CMD_SET_LOW     = 3'b110,
      CMD_ROT_END_LVL = 3'b111
   } pic_cmd_type;
endpackage : pic_pkg

/* include/pic_prio_if.sv */
`timescale 1ns/1ps
interface pic_prio_if;
   logic [7:0] pending;
   logic [7:0] mask;
   logic [7:0] service;
   logic [7:0] slaveMap;
   logic [2:0] lowest;
   logic       nestSpecial;
   logic       master;
   logic       winValid;
   logic [2:0] winLvl;
   logic       svcValid;
   logic [2:0] svcLvl;

   modport ctrl (output pending, mask, service, slaveMap, lowest, nestSpecial, master,
                 input  winValid, winLvl, svcValid, svcLvl);
   modport resolver (input  pending, mask, service, slaveMap, lowest, nestSpecial, master,
                     output winValid, winLvl, svcValid, svcLvl);
endinterface : pic_prio_if

/* src/pic_prio_resolve.sv */
`timescale 1ns/1ps
module pic_prio_resolve (
   pic_prio_if.resolver prio
);
   logic [2:0] lvl [8];
   logic [3:0] svcRank;

   // Rank 0 is the level just above the current lowest one
   genvar k;
   for (k = 0; k < 8; k++)
   begin : g_rank
      assign lvl[k] = prio.lowest + 3'(k + 1);
   end

   // Scan from rank 7 downward so rank 0 is taken last
   always_comb
   begin
      prio.svcValid = 1'b0;
      prio.svcLvl   = 3'h0;
      svcRank       = 4'h8;
      for (int i = 7; i >= 0; i--)
      begin
         if (prio.service[lvl[i]])
         begin
            prio.svcValid = 1'b1;
            prio.svcLvl   = lvl[i];
            svcRank       = 4'(i);
         end
      end
      prio.winValid = 1'b0;
      prio.winLvl   = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (prio.pending[lvl[i]] && !prio.mask[lvl[i]] &&
             (4'(i) < svcRank ||
              (4'(i) == svcRank && prio.nestSpecial && prio.master && prio.slaveMap[lvl[i]])))
         begin
            prio.winValid = 1'b1;
            prio.winLvl   = lvl[i];
         end
      end
   end
endmodule : pic_prio_resolve

/* tb/pic_host.sv */
`timescale 1ns/1ps
module pic_host (
   input  wire logic       mclk,
   input  wire logic [7:0] dataOut,
   input  wire logic       dataOe,
   output logic            csB,
   output logic            wrB,
   output logic            rdB,
   output logic            regSel,
   output logic      [7:0] dataIn,
   output logic            ackB
);
   initial
   begin
      csB    = 1'b1;
      wrB    = 1'b1;
      rdB    = 1'b1;
      regSel = 1'b0;
      dataIn = 8'h00;
      ackB   = 1'b1;
   end

   // One write per strobe, then an idle cycle before the next
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge mclk);
      csB    <= 1'b0;
      wrB    <= 1'b0;
      regSel <= sel;
      dataIn <= d;
      @(posedge mclk);
      csB    <= 1'b1;
      wrB    <= 1'b1;
      dataIn <= ~d; // Released bus never shows stale data
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic sel, output logic [7:0] d, output logic oe);
      @(posedge mclk);
      csB    <= 1'b0;
      rdB    <= 1'b0;
      regSel <= sel;
      @(posedge mclk);
      #1;
      d  = dataOut;
      oe = dataOe;
      @(posedge mclk);
      csB <= 1'b1;
      rdB <= 1'b1;
   endtask : rd

   // Pulses of two cycles low, three high between pulses; count depends on processor mode
   task automatic ack(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         ackB <= 1'b0;
         repeat (2) @(posedge mclk);
         ackB <= 1'b1;
         repeat (2) @(posedge mclk);
      end
   endtask : ack
endmodule : pic_host

/* tb/pic_cascade_mode_mask_eoi_config_test.sv */
`timescale 1ns/1ps
module pic_cascade_mode_mask_eoi_config_test;
   logic       mclk = 1'b0;
   logic       rst_b;
   logic       csB;
   logic       wrB;
   logic       rdB;
   logic       regSel;
   logic [7:0] dataIn;
   logic [7:0] dataOut;
   logic       dataOe;
   logic [7:0] reqIn;
   logic       ackB;
   logic       roleBufEnIn;
   logic       roleBufEnOut;
   logic       roleBufEnOe;
   logic       intReq;
   logic       isMaster;
   logic [7:0] slaveMap;
   logic [2:0] slaveId;
   logic       nestSpecial;
   logic       autoEnd;
   logic       procMode;
   logic       initDone;
   logic [7:0] d;
   logic       oe;
   int         badCount = 0;
   int         compares = 0;

   always #2 mclk = ~mclk;

   pic_ctrl dut (.mclk(mclk), .rst_b(rst_b), .csB(csB), .wrB(wrB), .rdB(rdB), .regSel(regSel),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .reqIn(reqIn), .ackB(ackB),
      .roleBufEnIn(roleBufEnIn), .roleBufEnOut(roleBufEnOut), .roleBufEnOe(roleBufEnOe),
      .intReq(intReq), .isMaster(isMaster), .slaveMap(slaveMap), .slaveId(slaveId),
      .nestSpecial(nestSpecial), .autoEnd(autoEnd), .procMode(procMode), .initDone(initDone));

   pic_host host (.mclk(mclk), .dataOut(dataOut), .dataOe(dataOe), .csB(csB), .wrB(wrB),
      .rdB(rdB), .regSel(regSel), .dataIn(dataIn), .ackB(ackB));

   task automatic summarize;
      $display("checks %0d mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         badCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : settle

   // Fresh rising edge, since request sensing is edge-triggered
   task automatic pulseReq(input int lvl);
      @(posedge mclk);
      reqIn <= reqIn & ~(8'h01 << lvl);
      @(posedge mclk);
      reqIn <= reqIn | (8'h01 << lvl);
      settle(3);
   endtask : pulseReq

   task automatic init(input logic [7:0] w1, input logic [7:0] casc, input logic [7:0] mode);
      host.wr(1'b0, w1);
      #1;
      chk({7'h0, initDone}, 8'h00);
      host.wr(1'b1, 8'h20);
      if (!w1[pic_pkg::SINGLE_BIT])
         host.wr(1'b1, casc);
      if (w1[pic_pkg::FOURTH_BIT])
         host.wr(1'b1, mode);
      settle(2);
   endtask : init

   initial
   begin
      #100000;
      badCount++;
      summarize();
   end

   initial
   begin
      rst_b       = 1'b0;
      roleBufEnIn = 1'b1;
      reqIn       = 8'h00;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      settle(1);
      chk({initDone, isMaster, nestSpecial, autoEnd, procMode, roleBufEnOe, roleBufEnOut, intReq}, 8'hc2);
      host.rd(1'b1, d, oe);
      chk(d, 8'h00);
      chk({7'h0, oe}, 8'h01);
      init(8'h11, 8'h24, 8'h1e);
      chk({3'h0, isMaster, nestSpecial, autoEnd, procMode, roleBufEnOe}, 8'h1d);
      chk(slaveMap, 8'h24);
      init(8'h11, 8'h05, 8'h09);
      chk({5'h0, isMaster, procMode, roleBufEnOe}, 8'h03);
      chk(slaveMap, 8'h00);
      chk({5'h0, slaveId}, 8'h05);
      @(posedge mclk);
      roleBufEnIn <= !roleBufEnIn;
      init(8'h11, 8'h00, 8'h00);
      chk({6'h0, isMaster, roleBufEnOe}, 8'h00);
      @(posedge mclk);
      roleBufEnIn <= !roleBufEnIn;
      settle(3);
      chk({7'h0, isMaster}, 8'h01);
      host.wr(1'b1, 8'h34);
      host.rd(1'b1, d, oe);
      chk(d, 8'h34);
      pulseReq(2);
      chk({7'h0, intReq}, 8'h00);
      host.rd(1'b0, d, oe);
      chk(d, 8'h04);
      host.wr(1'b1, 8'h00);
      settle(2);
      chk({7'h0, intReq}, 8'h01);
      host.ack(3);
      settle(2);
      chk({7'h0, intReq}, 8'h00);
      pulseReq(5);
      chk({7'h0, intReq}, 8'h00);
      host.wr(1'b0, 8'h20);
      settle(2);
      chk({7'h0, intReq}, 8'h01);
      host.ack(3);
      host.wr(1'b0, 8'hc2);
      pulseReq(2);
      chk({7'h0, intReq}, 8'h00);
      host.wr(1'b0, 8'h42);
      settle(2);
      chk({7'h0, intReq}, 8'h00);
      host.wr(1'b0, 8'h65);
      settle(2);
      chk({7'h0, intReq}, 8'h01);
      host.ack(3);
      host.wr(1'b0, 8'h20);
      init(8'h13, 8'h00, 8'h03);
      pulseReq(4);
      host.ack(2);
      settle(2);
      pulseReq(6);
      chk({7'h0, intReq}, 8'h01);
      host.ack(2);
      host.wr(1'b0, 8'h80);
      pulseReq(1);
      host.ack(2);
      @(posedge mclk);
      reqIn <= reqIn | 8'h09;
      settle(3);
      host.ack(2);
      host.rd(1'b0, d, oe);
      chk(d, 8'h01);
      summarize();
   end
endmodule : pic_cascade_mode_mask_eoi_config_test
